//--- hw/nsb_pkg.sv
package nsb_pkg;

	// ****************************************************
	// Register offsets on the serial port
	// ****************************************************
	localparam logic [6:0] ADR_MOTION = 7'h02;
	localparam logic [6:0] ADR_CFG_ONE = 7'h0f;
	localparam logic [6:0] ADR_FW_ENABLE = 7'h13;
	localparam logic [6:0] ADR_FMAX_LO = 7'h1a;
	localparam logic [6:0] ADR_FMAX_HI = 7'h1b;
	localparam logic [6:0] ADR_FMIN_LO = 7'h1c;
	localparam logic [6:0] ADR_FMIN_HI = 7'h1d;
	localparam logic [6:0] ADR_SHUT_LO = 7'h1e;
	localparam logic [6:0] ADR_SHUT_HI = 7'h1f;
	localparam logic [6:0] ADR_LASER = 7'h20;
	localparam logic [6:0] ADR_HEALTH = 7'h24;
	localparam logic [6:0] ADR_CRC_LO = 7'h25;
	localparam logic [6:0] ADR_CRC_HI = 7'h26;

	// ****************************************************
	// Reset values
	// ****************************************************
	localparam logic [7:0] RST_FMAX_LO = 8'hc0;
	localparam logic [7:0] RST_FMAX_HI = 8'h5d;
	localparam logic [7:0] RST_FMIN_LO = 8'ha0;
	localparam logic [7:0] RST_FMIN_HI = 8'h0f;
	localparam logic [7:0] RST_SHUT_LO = 8'h20;
	localparam logic [7:0] RST_SHUT_HI = 8'h4e;
	localparam logic [7:0] RST_LASER = 8'h01;
	localparam logic [7:0] RST_CFG_ONE = 8'h00;
	localparam logic [7:0] RST_HEALTH = 8'h00;
	localparam logic [7:0] RST_CRC = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;

	// ****************************************************
	// Field positions and codes
	// ****************************************************
	localparam int LASER_FORCE_BIT = 0;
	localparam int LASER_MODE_LSB = 1;
	localparam int LASER_MODE_MSB = 3;
	localparam logic [2:0] MODE_CONT_ON = 3'h2;
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam int CFG_GAIN_OFF_BIT = 4;
	localparam int HEALTH_FW_BIT = 6;
	localparam int HEALTH_FRAME_BITS = 6;
	localparam logic [7:0] FW_CRC_START = 8'h15;
	localparam int SETTLE_FRAMES = 2;

	// ****************************************************
	// Serial link framing
	// ****************************************************
	localparam int LINK_BYTE_BITS = 8;
	localparam int LINK_WR_FLAG = 7;
	localparam logic [3:0] LINK_ADDR_LAST = 4'h7;
	localparam logic [3:0] LINK_DATA_FIRST = 4'h8;
	localparam logic [3:0] LINK_DATA_LAST = 4'hf;

	typedef enum logic [1:0] {
		NSB_RUN = 2'b00,
		NSB_ARMED = 2'b01,
		NSB_SETTLE = 2'b10
	} nsb_act_t;

endpackage

//--- hw/nsb_link.sv
`timescale 1ns/1ps
module nsb_link import nsb_pkg::*; (
	input wire logic i_spi_clk,
	input wire logic i_cs_n,
	input wire logic i_rst_n,
	input wire logic i_mosi,
	input wire logic [7:0] i_rdata,
	output logic o_miso,
	output logic o_miso_oe,
	output logic [6:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_wr_tgl,
	output logic o_rd_tgl
);

	// ****************************************************
	// Frame state, cleared by the select line itself
	// ****************************************************
	// The link clock stops between frames, so the select
	// line rather than a clock edge ends each frame.
	logic [3:0] cnt_r;
	logic [6:0] sh_r;
	logic is_wr_r;
	logic [7:0] out_r;

	always_ff @(posedge i_spi_clk or posedge i_cs_n) begin
		if (i_cs_n) begin
			cnt_r <= '0;
			sh_r <= '0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			sh_r <= {sh_r[5:0], i_mosi};
		end
	end

	always_ff @(posedge i_spi_clk or posedge i_cs_n) begin
		if (i_cs_n) begin
			is_wr_r <= 1'b0;
		end else if (cnt_r == LINK_ADDR_LAST) begin
			is_wr_r <= sh_r[LINK_WR_FLAG - 1];
		end
	end

	// ****************************************************
	// Words and event toggles towards the core
	// ****************************************************
	// Toggles survive the frame end so no false event is seen.
	always_ff @(posedge i_spi_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_addr <= '0;
			o_wdata <= '0;
			o_wr_tgl <= 1'b0;
			o_rd_tgl <= 1'b0;
		end else if (cnt_r == LINK_ADDR_LAST) begin
			o_addr <= {sh_r[5:0], i_mosi};
			if (!sh_r[LINK_WR_FLAG - 1]) begin
				o_rd_tgl <= ~o_rd_tgl;
			end
		end else if (cnt_r == LINK_DATA_LAST && is_wr_r) begin
			o_wdata <= {sh_r, i_mosi};
			o_wr_tgl <= ~o_wr_tgl;
		end
	end

	// ****************************************************
	// Read data out on falling edges
	// ****************************************************
	// The read word is quasi-static: the core has held it
	// stable well before the controller resumes clocking.
	always_ff @(negedge i_spi_clk or posedge i_cs_n) begin
		if (i_cs_n) begin
			out_r <= '0;
		end else if (cnt_r == LINK_DATA_FIRST) begin
			out_r <= i_rdata;
		end else begin
			out_r <= {out_r[6:0], 1'b0};
		end
	end

	assign o_miso = out_r[LINK_BYTE_BITS - 1];
	assign o_miso_oe = !i_cs_n && !is_wr_r && cnt_r[3];

endmodule

//--- hw/nsb_regs.sv
`timescale 1ns/1ps
// Contract
// - New minimum frame period activates after both max period bytes are written.
// - Reading a pending bound returns the last value written to it.
// - Frame period is counted in oscillator cycles.
// - Automatic shutter choice never exceeds the maximum shutter bound.
// - New maximum shutter activates after both max period bytes are written.
// - With auto gain off the shutter equals the working maximum shutter bound.
// - Mode pattern 010b in laser bits 3 to 1 selects continuous-on.
// - Mode pattern 000b leaves continuous-on mode.
// - Any read of motion status at 0x02 clears the laser mode field.
// - Laser force bit set holds the active-low emitter enable disabled.
// - Each active process sets its own health bit every frame.
// - Health bit 6 reads one while running downloaded firmware.
// - CRC result registers hold the firmware check result, any read order.
// - Writing 0x15 to the firmware enable register starts the CRC check.
// - Bound writes before activation completes leave an undefined state.
module nsb_regs import nsb_pkg::*; #(
	parameter int PERIOD_W = 16,
	parameter int N_PROC = 6
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_spi_clk,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe,
	input wire logic [7:0] i_motion_status,
	input wire logic [PERIOD_W-1:0] i_auto_shutter,
	input wire logic i_exposure_on,
	input wire logic [N_PROC-1:0] i_process_flag,
	input wire logic i_shadow_firmware,
	input wire logic i_crc_done,
	input wire logic [15:0] i_crc_result,
	output logic o_crc_start,
	output logic o_frame_start,
	output logic [PERIOD_W-1:0] o_frame_period,
	output logic [PERIOD_W-1:0] o_frame_min,
	output logic [PERIOD_W-1:0] o_shutter,
	output logic o_laser_drive_mode,
	output logic o_emitter_enable_low,
	output logic o_bound_fault
);

	// ****************************************************
	// Link front end on the serial clock
	// ****************************************************
	logic [6:0] lk_addr;
	logic [7:0] lk_wdata;
	logic lk_wr_tgl;
	logic lk_rd_tgl;
	logic [7:0] rdata_r;

	nsb_link u_link (
		.i_spi_clk(i_spi_clk),
		.i_cs_n(i_cs_n),
		.i_rst_n(i_rst_n),
		.i_mosi(i_mosi),
		.i_rdata(rdata_r),
		.o_miso(o_miso),
		.o_miso_oe(o_miso_oe),
		.o_addr(lk_addr),
		.o_wdata(lk_wdata),
		.o_wr_tgl(lk_wr_tgl),
		.o_rd_tgl(lk_rd_tgl)
	);

	// ****************************************************
	// Toggle crossing into the oscillator domain
	// ****************************************************
	logic [1:0] wr_sync_r;
	logic [1:0] rd_sync_r;
	logic wr_seen_r;
	logic rd_seen_r;
	logic wr_ev;
	logic rd_ev;

	always_ff @(posedge i_ref_clk) begin
		wr_sync_r <= {wr_sync_r[0], lk_wr_tgl};
		rd_sync_r <= {rd_sync_r[0], lk_rd_tgl};
	end

	// Seen flags track the second stage so reset cannot fake an event.
	always_ff @(posedge i_ref_clk) begin
		wr_seen_r <= wr_sync_r[1];
		rd_seen_r <= rd_sync_r[1];
	end

	assign wr_ev = i_rst_n && (wr_sync_r[1] != wr_seen_r);
	assign rd_ev = i_rst_n && (rd_sync_r[1] != rd_seen_r);

	logic wr_fmax_lo;
	logic wr_fmax_hi;
	logic wr_bound;
	assign wr_fmax_lo = wr_ev && lk_addr == ADR_FMAX_LO;
	assign wr_fmax_hi = wr_ev && lk_addr == ADR_FMAX_HI;
	assign wr_bound = wr_ev && (lk_addr == ADR_FMIN_LO ||
		lk_addr == ADR_FMIN_HI || lk_addr == ADR_SHUT_LO ||
		lk_addr == ADR_SHUT_HI || wr_fmax_lo || wr_fmax_hi);

	// ****************************************************
	// Pending bound copies
	// ****************************************************
	logic [7:0] fmax_lo_r;
	logic [7:0] fmax_hi_r;
	logic [7:0] fmin_lo_r;
	logic [7:0] fmin_hi_r;
	logic [7:0] shut_lo_r;
	logic [7:0] shut_hi_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			fmax_lo_r <= RST_FMAX_LO;
			fmax_hi_r <= RST_FMAX_HI;
			fmin_lo_r <= RST_FMIN_LO;
			fmin_hi_r <= RST_FMIN_HI;
			shut_lo_r <= RST_SHUT_LO;
			shut_hi_r <= RST_SHUT_HI;
		end else if (wr_ev) begin
			unique case (lk_addr)
				ADR_FMAX_LO: begin
					fmax_lo_r <= lk_wdata;
				end
				ADR_FMAX_HI: begin
					fmax_hi_r <= lk_wdata;
				end
				ADR_FMIN_LO: begin
					fmin_lo_r <= lk_wdata;
				end
				ADR_FMIN_HI: begin
					fmin_hi_r <= lk_wdata;
				end
				ADR_SHUT_LO: begin
					shut_lo_r <= lk_wdata;
				end
				ADR_SHUT_HI: begin
					shut_hi_r <= lk_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************************
	// Activation sequencing
	// ****************************************************
	nsb_act_t act_r;
	logic lo_done_r;
	logic [1:0] settle_r;

	// A low byte must precede the high byte to count as both bytes.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			lo_done_r <= 1'b0;
		end else if (wr_fmax_lo) begin
			lo_done_r <= 1'b1;
		end else if (wr_fmax_hi) begin
			lo_done_r <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			act_r <= NSB_RUN;
			settle_r <= '0;
		end else begin
			unique case (act_r)
				NSB_RUN: begin
					if (wr_fmax_hi && lo_done_r) begin
						act_r <= NSB_ARMED;
					end
				end
				NSB_ARMED: begin
					if (o_frame_start) begin
						act_r <= NSB_SETTLE;
						settle_r <= 2'(SETTLE_FRAMES);
					end
				end
				NSB_SETTLE: begin
					if (o_frame_start) begin
						settle_r <= settle_r - 2'h1;
						if (settle_r == 2'h1) begin
							act_r <= NSB_RUN;
						end
					end
				end
				default: begin
					act_r <= NSB_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_bound_fault <= 1'b0;
		end else if (wr_bound && act_r != NSB_RUN) begin
			o_bound_fault <= 1'b1;
		end
	end

	// ****************************************************
	// Working bounds, loaded at a frame boundary
	// ****************************************************
	logic [PERIOD_W-1:0] shut_max_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_frame_period <= PERIOD_W'({RST_FMAX_HI, RST_FMAX_LO});
			o_frame_min <= PERIOD_W'({RST_FMIN_HI, RST_FMIN_LO});
			shut_max_r <= PERIOD_W'({RST_SHUT_HI, RST_SHUT_LO});
		end else if (act_r == NSB_ARMED && o_frame_start) begin
			o_frame_period <= PERIOD_W'({fmax_hi_r, fmax_lo_r});
			o_frame_min <= PERIOD_W'({fmin_hi_r, fmin_lo_r});
			shut_max_r <= PERIOD_W'({shut_hi_r, shut_lo_r});
		end
	end

	// ****************************************************
	// Frame timing
	// ****************************************************
	logic [PERIOD_W-1:0] fcnt_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			fcnt_r <= '0;
			o_frame_start <= 1'b0;
		end else if (fcnt_r + PERIOD_W'(1) >= o_frame_period) begin
			fcnt_r <= '0;
			o_frame_start <= 1'b1;
		end else begin
			fcnt_r <= fcnt_r + PERIOD_W'(1);
			o_frame_start <= 1'b0;
		end
	end

	// ****************************************************
	// Exposure selection
	// ****************************************************
	logic [7:0] cfg_one_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			cfg_one_r <= RST_CFG_ONE;
		end else if (wr_ev && lk_addr == ADR_CFG_ONE) begin
			cfg_one_r <= lk_wdata;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_shutter <= '0;
		end else if (cfg_one_r[CFG_GAIN_OFF_BIT]) begin
			o_shutter <= shut_max_r;
		end else if (i_auto_shutter > shut_max_r) begin
			o_shutter <= shut_max_r;
		end else begin
			o_shutter <= i_auto_shutter;
		end
	end

	// ****************************************************
	// Laser drive control
	// ****************************************************
	logic [2:0] laser_mode_r;
	logic laser_force_r;
	logic [7:0] laser_rst;
	assign laser_rst = RST_LASER;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			laser_mode_r <= laser_rst[LASER_MODE_MSB:LASER_MODE_LSB];
			laser_force_r <= laser_rst[LASER_FORCE_BIT];
		end else if (rd_ev && lk_addr == ADR_MOTION) begin
			laser_mode_r <= MODE_OFF;
		end else if (wr_ev && lk_addr == ADR_LASER) begin
			laser_mode_r <= lk_wdata[LASER_MODE_MSB:LASER_MODE_LSB];
			laser_force_r <= lk_wdata[LASER_FORCE_BIT];
		end
	end

	// Patterns other than the two defined ones act as off.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_laser_drive_mode <= 1'b0;
			o_emitter_enable_low <= 1'b1;
		end else begin
			o_laser_drive_mode <= laser_mode_r == MODE_CONT_ON;
			if (laser_force_r) begin
				o_emitter_enable_low <= 1'b1;
			end else if (laser_mode_r == MODE_CONT_ON) begin
				o_emitter_enable_low <= 1'b0;
			end else begin
				o_emitter_enable_low <= !i_exposure_on;
			end
		end
	end

	// ****************************************************
	// Process health flags
	// ****************************************************
	logic [7:0] health_r;
	logic health_wr;
	assign health_wr = wr_ev && lk_addr == ADR_HEALTH;

	genvar gi;
	generate
		for (gi = 0; gi < N_PROC; gi++) begin : g_flag
			always_ff @(posedge i_ref_clk) begin
				if (!i_rst_n) begin
					health_r[gi] <= RST_HEALTH[gi];
				end else if (i_process_flag[gi]) begin
					health_r[gi] <= 1'b1;
				end else if (health_wr) begin
					health_r[gi] <= lk_wdata[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			health_r[HEALTH_FW_BIT] <= RST_HEALTH[HEALTH_FW_BIT];
		end else begin
			health_r[HEALTH_FW_BIT] <= i_shadow_firmware;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			health_r[7] <= RST_HEALTH[7];
		end else if (health_wr) begin
			health_r[7] <= lk_wdata[7];
		end
	end

	// ****************************************************
	// Firmware check
	// ****************************************************
	logic [15:0] crc_r;

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_crc_start <= 1'b0;
		end else begin
			o_crc_start <= wr_ev && lk_addr == ADR_FW_ENABLE &&
				lk_wdata == FW_CRC_START;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			crc_r <= {RST_CRC, RST_CRC};
		end else if (i_crc_done) begin
			crc_r <= i_crc_result;
		end
	end

	// ****************************************************
	// Read data, held stable for the link
	// ****************************************************
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			rdata_r <= READ_NONE;
		end else if (rd_ev) begin
			unique case (lk_addr)
				ADR_MOTION: rdata_r <= i_motion_status;
				ADR_CFG_ONE: rdata_r <= cfg_one_r;
				ADR_FMAX_LO: rdata_r <= fmax_lo_r;
				ADR_FMAX_HI: rdata_r <= fmax_hi_r;
				ADR_FMIN_LO: rdata_r <= fmin_lo_r;
				ADR_FMIN_HI: rdata_r <= fmin_hi_r;
				ADR_SHUT_LO: rdata_r <= shut_lo_r;
				ADR_SHUT_HI: rdata_r <= shut_hi_r;
				ADR_LASER: rdata_r <= {4'h0, laser_mode_r,
					laser_force_r};
				ADR_HEALTH: rdata_r <= health_r;
				ADR_CRC_LO: rdata_r <= crc_r[7:0];
				ADR_CRC_HI: rdata_r <= crc_r[15:8];
				default: rdata_r <= READ_NONE;
			endcase
		end
	end

endmodule

//--- verif/nsb_regs_properties.sv
`timescale 1ns/1ps
module nsb_regs_checker #(
	parameter int PERIOD_W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic i_exposure_on,
	input wire logic o_miso_oe,
	input wire logic o_crc_start,
	input wire logic o_frame_start,
	input wire logic [PERIOD_W-1:0] o_frame_period,
	input wire logic [PERIOD_W-1:0] o_frame_min,
	input wire logic o_laser_drive_mode,
	input wire logic o_emitter_enable_low,
	input wire logic o_bound_fault
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	// ****************************************
	// Frame length tracker
	// ****************************************
	// The period is taken just after the pulse, since a new bound lands
	// at that same boundary and governs the frame that follows.
	logic [PERIOD_W-1:0] gap_r;
	logic [PERIOD_W-1:0] per_r;
	logic seen_r;
	logic mark_r;
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			gap_r <= '0;
			per_r <= '0;
			seen_r <= 1'b0;
			mark_r <= 1'b0;
		end else begin
			gap_r <= o_frame_start ? PERIOD_W'(1) : gap_r + 1'b1;
			mark_r <= o_frame_start;
			if (mark_r) begin
				per_r <= o_frame_period;
				seen_r <= 1'b1;
			end
		end
	end

	reset_state_a: assert property (
		$rose(i_rst_n) |-> o_emitter_enable_low && !o_frame_start
		&& !o_bound_fault && o_frame_period == 16'h5dc0
		&& o_frame_min == 16'h0fa0)
		else $error("outputs not at reset values after release");
	frame_gap_a: assert property (
		o_frame_start && seen_r |-> gap_r == per_r)
		else $error("frame length differs from working period");
	frame_pulse_a: assert property (
		o_frame_start |=> !o_frame_start)
		else $error("frame pulse longer than one cycle");
	bound_hold_a: assert property (
		$changed(o_frame_period) || $changed(o_frame_min)
		|-> o_frame_start || $past(o_frame_start))
		else $error("working bound changed inside a frame");
	fault_sticky_a: assert property (
		o_bound_fault |=> o_bound_fault)
		else $error("bound fault cleared without reset");
	crc_pulse_a: assert property (
		o_crc_start |=> !o_crc_start)
		else $error("check start longer than one cycle");
	emitter_cause_a: assert property (
		!o_emitter_enable_low |-> o_laser_drive_mode
		|| $past(o_laser_drive_mode) || $past(i_exposure_on))
		else $error("emitter lit without a cause");
	read_oe_a: assert property (
		o_miso_oe |-> !i_cs_n)
		else $error("serial output driven while deselected");
	addr_quiet_a: assert property (
		$fell(i_cs_n) |-> !o_miso_oe [*8])
		else $error("serial output driven during address byte");
endmodule

bind nsb_regs nsb_regs_checker #(.PERIOD_W(PERIOD_W)) i_chk (
	.i_ref_clk,
	.i_rst_n,
	.i_cs_n,
	.i_exposure_on,
	.o_miso_oe,
	.o_crc_start,
	.o_frame_start,
	.o_frame_period,
	.o_frame_min,
	.o_laser_drive_mode,
	.o_emitter_enable_low,
	.o_bound_fault
);

//--- verif/nsb_host_model.sv
`timescale 1ns/1ps
module nsb_host_model (
	output logic o_spi_clk,
	output logic o_cs_n,
	output logic o_mosi,
	input wire logic i_miso,
	input wire logic i_miso_oe
);
	initial begin
		o_spi_clk = 1'b1;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end

	// A bit seen while the device does not drive is unknown, never a guess.
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			o_spi_clk = 1'b0;
			o_mosi = tx[i];
			#15;
			o_spi_clk = 1'b1;
			rx[i] = i_miso_oe ? i_miso : 1'bx;
			#15;
		end
	endtask

	// One frame; the clock stands high between frames.
	task automatic xfer(input logic wr, input logic [6:0] adr,
		input logic [7:0] wd, output logic [7:0] rd);
		logic [7:0] junk;
		#2.7;
		o_cs_n = 1'b0;
		#15;
		shift({wr, adr}, junk);
		// Read data needs time to cross into the serial domain.
		if (!wr) #120;
		shift(wr ? wd : ~wd, rd);
		#15;
		o_cs_n = 1'b1;
		o_mosi = ~o_mosi;
		#150;
	endtask
endmodule

//--- verif/tb_nav_sensor_bound_laser_regs.sv
`timescale 1ns/1ps
module tb_nav_sensor_bound_laser_regs import nsb_pkg::*;;
	logic i_ref_clk;
	logic i_rst_n;
	logic i_spi_clk;
	logic i_cs_n;
	logic i_mosi;
	logic o_miso;
	logic o_miso_oe;
	logic [7:0] i_motion_status;
	logic [15:0] i_auto_shutter;
	logic i_exposure_on;
	logic [5:0] i_process_flag;
	logic i_shadow_firmware;
	logic i_crc_done;
	logic [15:0] i_crc_result;
	logic o_crc_start;
	logic o_frame_start;
	logic [15:0] o_frame_period;
	logic [15:0] o_frame_min;
	logic [15:0] o_shutter;
	logic o_laser_drive_mode;
	logic o_emitter_enable_low;
	logic o_bound_fault;
	int failures = 0;
	int num_checks = 0;
	int crc_seen = 0;

	typedef struct packed {logic wr; logic [6:0] a; logic [7:0] d;} nsb_row_t;
	nsb_row_t rows [19] = '{
		'{1'b0, ADR_LASER, RST_LASER},
		'{1'b0, ADR_SHUT_HI, RST_SHUT_HI},
		'{1'b0, ADR_SHUT_LO, RST_SHUT_LO},
		'{1'b0, ADR_FMAX_HI, RST_FMAX_HI},
		'{1'b0, ADR_FMAX_LO, RST_FMAX_LO},
		'{1'b0, ADR_FMIN_HI, RST_FMIN_HI},
		'{1'b0, ADR_FMIN_LO, RST_FMIN_LO},
		'{1'b0, 7'h7e, READ_NONE},
		'{1'b0, ADR_CRC_HI, RST_CRC},
		'{1'b1, ADR_SHUT_LO, 8'h00},
		'{1'b1, ADR_SHUT_HI, 8'h08},
		'{1'b0, ADR_SHUT_HI, 8'h08},
		'{1'b0, ADR_SHUT_LO, 8'h00},
		'{1'b1, ADR_FMIN_LO, 8'h00},
		'{1'b1, ADR_FMIN_HI, 8'h10},
		'{1'b0, ADR_FMIN_HI, 8'h10},
		'{1'b0, ADR_FMIN_LO, 8'h00},
		'{1'b1, ADR_LASER, 8'h05},
		'{1'b0, ADR_LASER, 8'h05}
	};

	nsb_regs i_dut (
		.i_ref_clk, .i_rst_n, .i_spi_clk, .i_cs_n, .i_mosi, .o_miso,
		.o_miso_oe, .i_motion_status, .i_auto_shutter, .i_exposure_on,
		.i_process_flag, .i_shadow_firmware, .i_crc_done, .i_crc_result,
		.o_crc_start, .o_frame_start, .o_frame_period, .o_frame_min,
		.o_shutter, .o_laser_drive_mode, .o_emitter_enable_low,
		.o_bound_fault
	);
	nsb_host_model i_host (
		.o_spi_clk(i_spi_clk),
		.o_cs_n(i_cs_n),
		.o_mosi(i_mosi),
		.i_miso(o_miso),
		.i_miso_oe(o_miso_oe)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		if (o_crc_start === 1'b1) crc_seen <= crc_seen + 1;
	end

	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk_byte(input logic [6:0] a, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] reg %h exp %h got %h", a, e, g);
		end
	endtask
	task automatic pchk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		i_host.xfer(1'b1, a, d, q);
		@(posedge i_ref_clk);
		#1;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		i_host.xfer(1'b0, a, 8'h00, q);
		chk_byte(a, e, q);
		@(posedge i_ref_clk);
		#1;
	endtask
	task automatic drive_shutter(input logic [15:0] v);
		@(posedge i_ref_clk);
		i_auto_shutter <= v;
		repeat (3) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic wait_frame();
		int k;
		for (k = 0; k < 30000; k++) begin
			@(posedge i_ref_clk);
			if (o_frame_start === 1'b1) break;
		end
		if (k == 30000) begin
			failures++;
			$display("[ERR] frame_start exp 1 got 0");
			end_sim();
		end
	endtask

	initial begin
		i_rst_n = 1'b0;
		i_motion_status = 8'h3c;
		i_auto_shutter = 16'h1000;
		i_exposure_on = 1'b0;
		i_process_flag = 6'h00;
		i_shadow_firmware = 1'b0;
		i_crc_done = 1'b0;
		i_crc_result = 16'h0000;
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		// Bound pairs are read high first and written low first.
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].a, rows[i].d);
			else rd(rows[i].a, rows[i].d);
		end
		pchk("frame_min", 16'h0fa0, o_frame_min);
		pchk("mode", 16'h1, o_laser_drive_mode);
		pchk("enable_low", 16'h1, o_emitter_enable_low);
		wr(ADR_LASER, 8'h04);
		pchk("enable_low", 16'h0, o_emitter_enable_low);
		rd(ADR_MOTION, 8'h3c);
		pchk("mode", 16'h0, o_laser_drive_mode);
		pchk("enable_low", 16'h1, o_emitter_enable_low);
		rd(ADR_LASER, 8'h00);
		@(posedge i_ref_clk);
		i_exposure_on <= 1'b1;
		wr(ADR_LASER, 8'h04);
		wr(ADR_LASER, 8'h00);
		pchk("mode", 16'h0, o_laser_drive_mode);
		pchk("enable_low", 16'h0, o_emitter_enable_low);
		@(posedge i_ref_clk);
		i_exposure_on <= 1'b0;
		wr(ADR_HEALTH, 8'h00);
		@(posedge i_ref_clk);
		i_process_flag <= 6'h29;
		i_shadow_firmware <= 1'b1;
		@(posedge i_ref_clk);
		i_process_flag <= 6'h00;
		rd(ADR_HEALTH, 8'h69);
		i_shadow_firmware <= 1'b0;
		wr(ADR_HEALTH, 8'h00);
		rd(ADR_HEALTH, 8'h00);
		wr(ADR_FW_ENABLE, FW_CRC_START);
		pchk("crc_start", 16'h1, 16'(crc_seen));
		wr(ADR_FW_ENABLE, 8'h14);
		pchk("crc_start", 16'h1, 16'(crc_seen));
		i_crc_result <= 16'hbeef;
		i_crc_done <= 1'b1;
		@(posedge i_ref_clk);
		i_crc_done <= 1'b0;
		rd(ADR_CRC_LO, 8'hef);
		rd(ADR_CRC_HI, 8'hbe);
		rd(ADR_CRC_LO, 8'hef);
		pchk("shutter", 16'h1000, o_shutter);
		wr(ADR_CFG_ONE, 8'h10);
		pchk("shutter", 16'h4e20, o_shutter);
		wr(ADR_CFG_ONE, 8'h00);
		drive_shutter(16'h9000);
		pchk("shutter", 16'h4e20, o_shutter);
		// Period 0x1980 covers min 0x1000 plus shutter 0x0800.
		wr(ADR_FMAX_LO, 8'h80);
		wr(ADR_FMAX_HI, 8'h19);
		pchk("frame_min", 16'h0fa0, o_frame_min);
		wait_frame();
		repeat (3) @(posedge i_ref_clk);
		#1;
		pchk("frame_period", 16'h1980, o_frame_period);
		pchk("frame_min", 16'h1000, o_frame_min);
		pchk("shutter", 16'h0800, o_shutter);
		wait_frame();
		wait_frame();
		drive_shutter(16'h0400);
		pchk("shutter", 16'h0400, o_shutter);
		wr(ADR_CFG_ONE, 8'h10);
		pchk("shutter", 16'h0800, o_shutter);
		pchk("bound_fault", 16'h0, o_bound_fault);
		wr(ADR_FMAX_LO, 8'h80);
		wr(ADR_FMAX_HI, 8'h19);
		wr(ADR_SHUT_LO, 8'h00);
		pchk("bound_fault", 16'h1, o_bound_fault);
		@(posedge i_ref_clk);
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		#1;
		pchk("bound_fault", 16'h0, o_bound_fault);
		pchk("frame_period", 16'h5dc0, o_frame_period);
		pchk("enable_low", 16'h1, o_emitter_enable_low);
		rd(ADR_SHUT_HI, RST_SHUT_HI);
		end_sim();
	end
endmodule
